// ==== nvs_pkg.sv ====
package nvs_pkg;

  // ****************************************************
  // Image geometry
  // ****************************************************
  localparam int unsigned NVS_SIZE = 80; // Bytes in the parameter image
  localparam logic [7:0] NVS_LAST_POS = 8'h4f; // Highest usable position
  localparam logic [8:0] NVS_END = 9'h050; // Position plus count limit
  localparam logic [6:0] NVS_IDX_LAST = 7'h4f; // Last index for the boot copy
  localparam logic [6:0] NVS_IDX_ONE = 7'h01; // Index step
  localparam logic [7:0] NVS_CNT_ONE = 8'h01; // Count step

  // ****************************************************
  // Parameter positions (two-byte values sit low byte first, except the sync word, high byte first)
  // ****************************************************
  localparam logic [6:0] POS_SERIAL_FORMAT_CTL = 7'h00;
  localparam logic [6:0] POS_SERIAL_CLOCK_SOURCE = 7'h01;
  localparam logic [6:0] POS_BAUD_MODULATION = 7'h02;
  localparam logic [6:0] POS_BAUD_PRESCALE_LOW = 7'h03;
  localparam logic [6:0] POS_BAUD_PRESCALE_HIGH = 7'h04;
  localparam logic [6:0] POS_PACKET_METHOD = 7'h05;
  localparam logic [6:0] POS_PACKET_LENGTH_LIMIT = 7'h07;
  localparam logic [6:0] POS_FLOW_STOP_THRESHOLD = 7'h08;
  localparam logic [6:0] POS_END_MARKER_CHAR = 7'h09;
  localparam logic [6:0] POS_IDLE_SEND_TIMEOUT = 7'h0c;
  localparam logic [6:0] POS_INDICATION_DELAY = 7'h0e;
  localparam logic [6:0] POS_RETRY_COUNT = 7'h14;
  localparam logic [6:0] POS_ADDRESSING_SCHEME = 7'h15;
  localparam logic [6:0] POS_TARGET_NETWORK_ID = 7'h18;
  localparam logic [6:0] POS_TARGET_NODE_ADDR = 7'h19;
  localparam logic [6:0] POS_OWN_NETWORK_ID = 7'h1c;
  localparam logic [6:0] POS_OWN_NODE_ADDR = 7'h1d;
  localparam logic [6:0] POS_ACK_WAIT_TIME = 7'h20;
  localparam logic [6:0] POS_TX_PREFILL_LEVEL = 7'h28;
  localparam logic [6:0] POS_TX_OUTPUT_POWER = 7'h29;
  localparam logic [6:0] POS_STARTUP_CHANNEL = 7'h2a;
  localparam logic [6:0] POS_CLEAR_CHANNEL_LEVEL = 7'h2b;
  localparam logic [6:0] POS_STARTUP_OP_MODE = 7'h3c;
  localparam logic [6:0] POS_OSCILLATOR_TRIM_START = 7'h3d;
  localparam logic [6:0] POS_WAKE_CYCLE_LENGTH = 7'h40;
  localparam logic [6:0] POS_WAKE_CYCLE_COUNT = 7'h42;
  localparam logic [6:0] POS_WAKE_LISTEN_TIME = 7'h44;
  localparam logic [6:0] POS_CONFIG_FLAG_WORD = 7'h48;
  localparam logic [6:0] POS_SYNC_WORD_HIGH = 7'h4c;
  localparam logic [6:0] POS_SYNC_WORD_LOW = 7'h4d;

  // ****************************************************
  // Set and get answer codes
  // ****************************************************
  localparam logic [7:0] NVS_ST_OK = 8'h00;
  localparam logic [7:0] NVS_ST_BAD_POS = 8'h01;
  localparam logic [7:0] NVS_ST_BAD_CNT = 8'h02;

  // Runtime copies start out cleared before the boot copy
  localparam logic [7:0] NVS_RUN_CLEAR = 8'h00;

  // Kind of host command
  typedef enum logic {
    NVS_CMD_SET,
    NVS_CMD_GET
  } nvs_cmd_t;

  // Sequencer states
  typedef enum logic [2:0] {
    NVS_LOAD,
    NVS_IDLE,
    NVS_SET_DATA,
    NVS_GET_DATA,
    NVS_RESP
  } nvs_state_t;

  // Factory content of one image byte
  function automatic logic [7:0] nvs_default(input logic [6:0] pos);
    unique case (pos)
      POS_SERIAL_CLOCK_SOURCE: nvs_default = 8'h80;
      POS_BAUD_MODULATION: nvs_default = 8'h92;
      POS_BAUD_PRESCALE_LOW: nvs_default = 8'h41;
      POS_BAUD_PRESCALE_HIGH: nvs_default = 8'h03;
      POS_PACKET_LENGTH_LIMIT: nvs_default = 8'h80;
      POS_FLOW_STOP_THRESHOLD: nvs_default = 8'h70;
      POS_END_MARKER_CHAR: nvs_default = 8'h0a;
      POS_IDLE_SEND_TIMEOUT: nvs_default = 8'h05;
      POS_ACK_WAIT_TIME: nvs_default = 8'h08;
      POS_TX_PREFILL_LEVEL: nvs_default = 8'h08;
      POS_TX_OUTPUT_POWER: nvs_default = 8'hc3;
      POS_STARTUP_CHANNEL: nvs_default = 8'h0a;
      POS_OSCILLATOR_TRIM_START: nvs_default = 8'h07;
      7'h41: nvs_default = 8'h10; // High byte of wake cycle length
      POS_WAKE_CYCLE_COUNT: nvs_default = 8'h05;
      POS_WAKE_LISTEN_TIME: nvs_default = 8'he8;
      7'h45: nvs_default = 8'h03; // High byte of wake listen time
      POS_SYNC_WORD_HIGH: nvs_default = 8'hd3;
      POS_SYNC_WORD_LOW: nvs_default = 8'h91;
      default: nvs_default = 8'h00;
    endcase
  endfunction

  // Radio group: transmitter block and sync word
  function automatic logic nvs_is_radio(input logic [6:0] pos);
    nvs_is_radio = (pos >= POS_TX_PREFILL_LEVEL && pos <= POS_CLEAR_CHANNEL_LEVEL) ||
                   pos == POS_SYNC_WORD_HIGH || pos == POS_SYNC_WORD_LOW;
  endfunction

endpackage

// ==== nvs_flash_store.sv ====
module nvs_flash_store
  import nvs_pkg::*;
(
  input wire logic clk,
  input wire logic por_n,
  input wire logic wr_en,
  input wire logic [6:0] wr_pos,
  input wire logic [7:0] wr_byte,
  input wire logic [6:0] rd_pos,
  output logic [7:0] rd_byte
);

  // ****************************************************
  // Non-volatile image
  // ****************************************************
  // Held across rst_n; only power-on puts the factory image back
  logic [7:0] image_reg [NVS_SIZE];

  // Byte writes, factory content at power-on
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < NVS_SIZE; i++) begin
        image_reg[i] <= nvs_default(7'(i));
      end
    end else if (wr_en) begin
      image_reg[wr_pos] <= wr_byte;
    end
  end

  // Plain read port
  assign rd_byte = image_reg[rd_pos];

endmodule

// ==== nvs_settings_store.sv ====
// Contract
// - Boot copies whole stored image to runtime
// - Runtime edits lost, reloaded at restart
// - Runtime commands change copies, not store
// - Set command in command mode writes store
// - New stored values act only after reset
// - Stored bytes taken without range checks
// - Set command never alters radio group
// - Image byte addressed; words at even positions (baud prescale sits at 3 and 4 here)
// - Clock source byte defaults to 128
// - Baud prescale split low/high, modulation default
// - Retry count byte at position 20
// - Flag word sixteen bits at position 72
// - Multi-byte values travel low byte first; the sync word goes high byte first
// - No access past position 79
// - Set answer codes success, position, count
module nvs_settings_store
  import nvs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  // Command port from the framing layer
  input wire logic cmd_mode,
  input wire logic cmd_start,
  input wire nvs_cmd_t cmd_kind,
  input wire logic [7:0] cmd_pos,
  input wire logic [7:0] cmd_cnt,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  // Runtime commands
  input wire logic rt_channel_we,
  input wire logic rt_dest_net_we,
  input wire logic rt_dest_addr_we,
  input wire logic [7:0] rt_value,
  // Answers to the host
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_status,
  output logic out_valid,
  output logic [7:0] out_byte,
  // Boot status and runtime view
  output logic boot_done,
  output logic [NVS_SIZE*8-1:0] run_image
);

  // ****************************************************
  // Declarations
  // ****************************************************
  // Sequencer, position and count
  nvs_state_t state_reg; // Sequencer state
  nvs_state_t state_next; // Its next value
  logic [6:0] idx_reg; // Current image position
  logic [7:0] left_reg; // Bytes still to move

  // Registered outputs
  logic [7:0] status_reg; // Answer code of the command
  logic cmd_ready_reg; // Command port free
  logic rsp_valid_reg; // Answer strobe
  logic out_valid_reg; // Read byte strobe
  logic [7:0] out_byte_reg; // Read byte
  logic boot_done_reg; // Runtime copy complete

  // Volatile copy of the image
  logic [7:0] run_reg [NVS_SIZE]; // Volatile runtime copy

  // Decode of the command port
  logic [7:0] check_status; // Range check of a new command
  logic [8:0] span_end; // Position plus count
  logic take_cmd; // New command accepted this cycle
  logic [6:0] rd_pos; // Store read position
  logic [7:0] rd_byte; // Store read data
  logic store_we; // Store write strobe
  logic last_byte; // Final byte of a transfer

  // ****************************************************
  // Command acceptance and range check
  // ****************************************************
  // Only in command mode and while the port is free
  // A start outside these is dropped with no sign;
  // the host sees only a missing answer
  // and may simply try again later
  assign take_cmd = cmd_start && cmd_mode && state_reg == NVS_IDLE;

  // End of the requested span, one bit wider to catch carry
  // Both fields are eight bits,
  // so nine bits hold any sum
  assign span_end = {1'b0, cmd_pos} + {1'b0, cmd_cnt};

  // Position first, then count
  // A bad position wins over a bad count;
  // a zero count is a bad count
  // and moves no byte at all
  always_comb begin
    if (cmd_pos > NVS_LAST_POS) begin
      check_status = NVS_ST_BAD_POS;
    end else if (cmd_cnt == 8'h00 || span_end > NVS_END) begin
      check_status = NVS_ST_BAD_CNT;
    end else begin
      check_status = NVS_ST_OK;
    end
  end

  // Last byte of a write or read burst
  // The count never reaches zero inside a burst,
  // since zero counts are refused up front
  assign last_byte = (left_reg == NVS_CNT_ONE);

  // ****************************************************
  // Sequencer
  // ****************************************************
  // Next state decode
  // Bad requests skip the data states
  // and answer straight away;
  // good ones move their bytes first
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      NVS_LOAD: begin
        // Copy runs over every position once
        if (idx_reg == NVS_IDX_LAST) begin
          state_next = NVS_IDLE;
        end
      end
      NVS_IDLE: begin
        // Bad requests answer at once
        if (take_cmd) begin
          if (check_status != NVS_ST_OK) begin
            state_next = NVS_RESP;
          end else if (cmd_kind == NVS_CMD_SET) begin
            state_next = NVS_SET_DATA;
          end else begin
            state_next = NVS_GET_DATA;
          end
        end
      end
      NVS_SET_DATA: begin
        // Waits on each payload byte
        if (in_valid && last_byte) begin
          state_next = NVS_RESP;
        end
      end
      NVS_GET_DATA: begin
        // One byte out per cycle
        if (last_byte) begin
          state_next = NVS_RESP;
        end
      end
      NVS_RESP: begin
        state_next = NVS_IDLE;
      end
      default: begin
        // Unused codes restart the boot copy
        state_next = NVS_LOAD;
      end
    endcase
  end

  // State register; every reset restarts the boot copy
  // A reset mid-command drops the command;
  // store bytes already written stay written
  // and the copy picks them up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= NVS_LOAD;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************
  // Position and byte counters
  // ****************************************************
  // Start at the request position, step once per byte
  // Load walks all positions; left_reg unused there
  // A refused request loads too,
  // but no burst follows it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= POS_SERIAL_FORMAT_CTL;
      left_reg <= 8'h00;
    end else if (take_cmd) begin
      idx_reg <= cmd_pos[6:0];
      left_reg <= cmd_cnt;
    end else if (state_reg == NVS_LOAD) begin
      idx_reg <= idx_reg + NVS_IDX_ONE;
    end else if (state_reg == NVS_GET_DATA ||
                 (state_reg == NVS_SET_DATA && in_valid)) begin
      // Ascending positions keep two-byte values low byte first, the sync word high byte first
      idx_reg <= idx_reg + NVS_IDX_ONE;
      left_reg <= left_reg - NVS_CNT_ONE;
    end
  end

  // ****************************************************
  // Answer code
  // ****************************************************
  // Latched when the command is taken
  // Held until the next command is taken,
  // so the host may read it late
  // or after the strobe has gone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= NVS_ST_OK;
    end else if (take_cmd) begin
      status_reg <= check_status;
    end
  end

  // ****************************************************
  // Store access
  // ****************************************************
  // Reads follow the running position in load and get
  // Load and get never overlap,
  // so one read port serves both
  assign rd_pos = idx_reg;

  // Payload goes in untouched, radio positions are skipped
  // Radio bytes still count down,
  // so the answer and the length
  // look normal to the host
  assign store_we = state_reg == NVS_SET_DATA && in_valid &&
                    !nvs_is_radio(idx_reg);

  // Persistent image, only power-on restores factory content
  // Reads are combinational; a get byte
  // leaves one cycle after its position
  // is presented
  nvs_flash_store u_store (
    .clk(clk),
    .por_n(por_n),
    .wr_en(store_we),
    .wr_pos(idx_reg),
    .wr_byte(in_byte),
    .rd_pos(rd_pos),
    .rd_byte(rd_byte)
  );

  // ****************************************************
  // Runtime copy
  // ****************************************************
  // Loaded at boot, then only the runtime commands touch it;
  // store writes never reach it until the next reset
  // Runtime writes during the copy are dropped;
  // the copy itself always wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NVS_SIZE; i++) begin
        run_reg[i] <= NVS_RUN_CLEAR;
      end
    end else if (state_reg == NVS_LOAD) begin
      run_reg[idx_reg] <= rd_byte;
    end else begin
      // Volatile edits of channel and destination
      // Each strobe touches one position;
      // all three may land in one cycle
      if (rt_channel_we) begin
        run_reg[POS_STARTUP_CHANNEL] <= rt_value;
      end
      if (rt_dest_net_we) begin
        run_reg[POS_TARGET_NETWORK_ID] <= rt_value;
      end
      if (rt_dest_addr_we) begin
        run_reg[POS_TARGET_NODE_ADDR] <= rt_value;
      end
    end
  end

  // Flattened view, position 0 in the low byte
  // Pure wiring from run_reg to the port,
  // so the view is flop-true
  always_comb begin
    run_image = '0;
    for (int i = 0; i < NVS_SIZE; i++) begin
      run_image[i*8 +: 8] = run_reg[i];
    end
  end

  // ****************************************************
  // Read data path
  // ****************************************************
  // Get bytes come from the store, not the runtime copy
  // One byte per cycle with no wait;
  // the host has to take every strobe
  // Data holds its last byte when idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_byte_reg <= 8'h00;
    end else if (state_reg == NVS_GET_DATA) begin
      out_valid_reg <= 1'b1;
      out_byte_reg <= rd_byte;
    end else begin
      out_valid_reg <= 1'b0;
    end
  end

  // ****************************************************
  // Answer strobe and port status
  // ****************************************************
  // One-cycle answer after the last byte or a refusal
  // Never high together with a get byte,
  // the last byte stands a cycle before
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= (state_reg == NVS_RESP);
    end
  end

  // Ready whenever the sequencer will sit idle
  // Looks ahead so ready rises
  // in the answer cycle, and a start
  // in that cycle is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready_reg <= 1'b0;
    end else begin
      cmd_ready_reg <= (state_next == NVS_IDLE);
    end
  end

  // Set once the boot copy ends, held until reset
  // Commands wait on it through cmd_ready;
  // a status only, nothing is gated here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_done_reg <= 1'b0;
    end else if (state_reg == NVS_LOAD && idx_reg == NVS_IDX_LAST) begin
      boot_done_reg <= 1'b1;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Every output is a flop,
  // no logic on the way out
  assign cmd_ready = cmd_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  // Status outlives the strobe until the next take
  assign rsp_status = status_reg;
  assign out_valid = out_valid_reg;
  assign out_byte = out_byte_reg;
  assign boot_done = boot_done_reg;

endmodule

// ==== nvs_store_chk.sv ====
module nvs_store_chk
  import nvs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic cmd_mode,
  input wire logic cmd_start,
  input wire nvs_cmd_t cmd_kind,
  input wire logic [7:0] cmd_pos,
  input wire logic [7:0] cmd_cnt,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic rt_channel_we,
  input wire logic rt_dest_net_we,
  input wire logic rt_dest_addr_we,
  input wire logic [7:0] rt_value,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_status,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  input wire logic boot_done,
  input wire logic [NVS_SIZE*8-1:0] run_image
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Helper logic
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic take; // Command accepted this cycle
  logic [7:0] boot_cnt_reg; // Cycles since reset release
  logic [7:0] cnt_reg; // Byte count of the running command
  logic [7:0] outs_reg; // Get bytes seen so far
  nvs_cmd_t kind_reg; // Kind of the running command
  assign take = cmd_start && cmd_mode && cmd_ready;
  // Boot length counter, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_reg <= 8'h00;
    end else if (!boot_done && boot_cnt_reg != 8'hff) begin
      boot_cnt_reg <= boot_cnt_reg + 8'h01;
    end
  end
  // Latch command, count returned bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_reg <= NVS_CMD_SET;
      cnt_reg <= 8'h00;
      outs_reg <= 8'h00;
    end else if (take) begin
      kind_reg <= cmd_kind;
      cnt_reg <= cmd_cnt;
      outs_reg <= 8'h00;
    end else if (out_valid) begin
      outs_reg <= outs_reg + 8'h01;
    end
  end
  // ****
  // Assertions
  // ****
  a_boot_len: assert property ($rose(boot_done) |-> boot_cnt_reg == 8'h50)
    else $error("boot copy length wrong");
  a_boot_quiet: assert property (!boot_done |-> !cmd_ready && !out_valid && !rsp_valid)
    else $error("activity before boot copy done");
  a_bad_pos: assert property (take && cmd_pos > NVS_LAST_POS |->
    ##2 rsp_valid && rsp_status == NVS_ST_BAD_POS) else $error("bad position answer wrong");
  a_bad_cnt: assert property (take && cmd_pos <= NVS_LAST_POS && (cmd_cnt == 8'h00 ||
    {1'b0, cmd_pos} + {1'b0, cmd_cnt} > NVS_END) |-> ##2 rsp_valid && rsp_status == NVS_ST_BAD_CNT)
    else $error("bad count answer wrong");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && !out_valid)
    else $error("answer not a single pulse");
  a_get_count: assert property (rsp_valid && kind_reg == NVS_CMD_GET &&
    rsp_status == NVS_ST_OK |-> outs_reg == cnt_reg) else $error("get byte count wrong");
  a_status_hold: assert property ($changed(rsp_status) |-> rsp_valid || !cmd_ready)
    else $error("status changed while idle");
  a_rt_channel: assert property (rt_channel_we && boot_done |=>
    run_image[42*8 +: 8] == $past(rt_value)) else $error("runtime channel not taken");
  a_rt_net: assert property (rt_dest_net_we && boot_done |=>
    run_image[24*8 +: 8] == $past(rt_value)) else $error("runtime network id not taken");
  a_rt_addr: assert property (rt_dest_addr_we && boot_done |=>
    run_image[25*8 +: 8] == $past(rt_value)) else $error("runtime address not taken");
  c_get: cover property (take && cmd_kind == NVS_CMD_GET);
  c_set: cover property (take && cmd_kind == NVS_CMD_SET);
  c_bad: cover property (rsp_valid && rsp_status == NVS_ST_BAD_CNT);
endmodule

// ==== nvs_host_model.sv ====
module nvs_host_model
  import nvs_pkg::*;
(
  input wire logic clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_status,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  output logic cmd_mode,
  output logic cmd_start,
  output nvs_cmd_t cmd_kind,
  output logic [7:0] cmd_pos,
  output logic [7:0] cmd_cnt,
  output logic in_valid,
  output logic [7:0] in_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wdata [80]; // Payload by image position
  logic [7:0] rdata [80]; // Bytes returned by the last get
  int rn; // Count of returned bytes
  // Idle levels at time zero
  initial begin
    cmd_mode = 1'b1;
    cmd_start = 1'b0;
    cmd_kind = NVS_CMD_GET;
    cmd_pos = 8'h00;
    cmd_cnt = 8'h00;
    in_valid = 1'b0;
    in_byte = 8'h00;
  end
  // One command; st stays 8'hee when no answer comes
  task automatic run(input nvs_cmd_t k, input logic [7:0] p, input logic [7:0] c,
                     output logic [7:0] st);
    int i;
    int t;
    bit ok;
    st = 8'hee;
    rn = 0;
    i = 0;
    ok = cmd_mode && p <= 8'h4f && c != 8'h00 && {1'b0, p} + {1'b0, c} <= 9'h050;
    for (t = 0; t < 200 && !cmd_ready; t++) begin
      @(posedge clk);
      #1;
    end
    cmd_start = 1'b1;
    cmd_kind = k;
    cmd_pos = p;
    cmd_cnt = c;
    @(posedge clk);
    #1;
    cmd_start = 1'b0;
    cmd_pos = ~p; // Released fields lose their value
    cmd_cnt = ~c;
    for (t = 0; t < 300; t++) begin
      if (k == NVS_CMD_SET && ok && i < c) begin
        in_valid = 1'b1;
        in_byte = wdata[p + i];
        i++;
      end else begin
        in_valid = 1'b0;
        in_byte = ~in_byte;
      end
      @(posedge clk);
      if (out_valid) begin
        rdata[rn] = out_byte;
        rn++;
      end
      if (rsp_valid) begin
        st = rsp_status;
        t = 300;
      end
      #1;
    end
    in_valid = 1'b0;
  endtask
endmodule

// ==== tb.sv ====
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end \
end
module tb
  import nvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0;
  logic rt_channel_we = 1'b0, rt_dest_net_we = 1'b0, rt_dest_addr_we = 1'b0;
  logic [7:0] rt_value = 8'h00;
  logic cmd_mode, cmd_start, in_valid, cmd_ready, rsp_valid, out_valid, boot_done;
  nvs_cmd_t cmd_kind;
  logic [7:0] cmd_pos, cmd_cnt, in_byte, rsp_status, out_byte, st;
  logic [NVS_SIZE*8-1:0] run_image;
  logic [7:0] img [80]; // Expected store
  logic [7:0] run_exp [80]; // Expected runtime copy
  int fail_count = 0, cmp_count = 0, cyc = 0, k;
  // Factory content: position, value
  localparam logic [15:0] DEF [19] = '{16'h0180, 16'h0292, 16'h0341, 16'h0403, 16'h0780,
    16'h0870, 16'h090a, 16'h0c05, 16'h2008, 16'h2808, 16'h29c3, 16'h2a0a, 16'h3d07,
    16'h4110, 16'h4205, 16'h44e8, 16'h4503, 16'h4cd3, 16'h4d91};
  // Bad ranges: kind, position, count
  localparam logic [16:0] BAD [5] = '{17'h15001, 17'h04f02, 17'h00000, 17'h1ff01, 17'h00051};
  nvs_settings_store i_nvs_settings_store (.clk, .rst_n, .por_n, .cmd_mode, .cmd_start,
    .cmd_kind, .cmd_pos, .cmd_cnt, .in_valid, .in_byte, .rt_channel_we, .rt_dest_net_we,
    .rt_dest_addr_we, .rt_value, .cmd_ready, .rsp_valid, .rsp_status, .out_valid, .out_byte,
    .boot_done, .run_image);
  nvs_host_model i_nvs_host_model (.clk, .cmd_ready, .rsp_valid, .rsp_status, .out_valid,
    .out_byte, .cmd_mode, .cmd_start, .cmd_kind, .cmd_pos, .cmd_cnt, .in_valid, .in_byte);
  always #10 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask
  // Reset, optionally with power-on, then wait for the boot copy
  task automatic boot(input bit por);
    int n;
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    if (por) por_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    por_n = 1'b1;
    for (n = 0; n < 200 && boot_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    run_exp = img;
  endtask
  task automatic chk_run(input string nm);
    for (int n = 0; n < 80; n++) `CHK(nm, run_exp[n], run_image[8*n +: 8])
    end_test(nm);
  endtask
  task automatic get_all(input string nm);
    i_nvs_host_model.run(NVS_CMD_GET, 8'h00, 8'h50, st);
    `CHK(nm, NVS_ST_OK, st)
    `CHK(nm, 80, i_nvs_host_model.rn)
    for (int n = 0; n < 80; n++) `CHK(nm, img[n], i_nvs_host_model.rdata[n])
    end_test(nm);
  endtask
  // Set up to four bytes, low byte first; radio bytes stay unchanged
  task automatic setw(input logic [7:0] p, input logic [7:0] c, input logic [31:0] v);
    int q;
    for (int n = 0; n < c; n++) begin
      q = p + n;
      i_nvs_host_model.wdata[q] = v[8*n +: 8];
      if (!((q >= 40 && q <= 43) || q == 76 || q == 77)) img[q] = v[8*n +: 8];
    end
    i_nvs_host_model.run(NVS_CMD_SET, p, c, st);
    `CHK("set status", NVS_ST_OK, st)
  endtask
  // Runtime write pulse, mask {channel, net, addr}
  task automatic rt_wr(input logic [2:0] m, input logic [7:0] v);
    rt_value = v;
    {rt_channel_we, rt_dest_net_we, rt_dest_addr_we} = m;
    @(posedge clk);
    #1;
    {rt_channel_we, rt_dest_net_we, rt_dest_addr_we} = 3'h0;
    @(posedge clk);
    #1;
  endtask
  // ****
  // Test sequence
  // ****
  initial begin
    for (k = 0; k < 80; k++) img[k] = 8'h00;
    for (k = 0; k < 19; k++) img[DEF[k][15:8]] = DEF[k][7:0];
    boot(1'b1);
    chk_run("boot copy");
    get_all("factory get");
    setw(8'h14, 8'h01, 32'h000000ff);
    setw(8'h48, 8'h02, 32'h00001234);
    setw(8'h02, 8'h03, 32'h00050607);
    setw(8'h28, 8'h04, 32'h11223344);
    setw(8'h4c, 8'h02, 32'h00005566);
    setw(8'h4e, 8'h02, 32'h0000beef);
    chk_run("no early effect");
    get_all("stored get");
    for (k = 0; k < 5; k++) begin
      i_nvs_host_model.run(nvs_cmd_t'(BAD[k][16]), BAD[k][15:8], BAD[k][7:0], st);
      `CHK("bad range", BAD[k][15:8] > 8'h4f ? NVS_ST_BAD_POS : NVS_ST_BAD_CNT, st)
      `CHK("bad range bytes", 0, i_nvs_host_model.rn)
    end
    end_test("bad ranges");
    i_nvs_host_model.cmd_mode = 1'b0;
    i_nvs_host_model.wdata[20] = 8'h77;
    i_nvs_host_model.run(NVS_CMD_SET, 8'h14, 8'h01, st);
    `CHK("mode off", 8'hee, st)
    end_test("mode off");
    i_nvs_host_model.cmd_mode = 1'b1;
    get_all("after refusals");
    rt_wr(3'h4, 8'h33);
    rt_wr(3'h2, 8'h44);
    rt_wr(3'h1, 8'h55);
    run_exp[42] = 8'h33;
    run_exp[24] = 8'h44;
    run_exp[25] = 8'h55;
    chk_run("runtime writes");
    get_all("store kept");
    boot(1'b0);
    chk_run("restart");
    complete_run();
  end
endmodule
bind nvs_settings_store nvs_store_chk i_chk (.clk, .rst_n, .por_n, .cmd_mode, .cmd_start,
  .cmd_kind, .cmd_pos, .cmd_cnt, .in_valid, .in_byte, .rt_channel_we, .rt_dest_net_we,
  .rt_dest_addr_we, .rt_value, .cmd_ready, .rsp_valid, .rsp_status, .out_valid, .out_byte,
  .boot_done, .run_image);
